// >>> logic/hsp_map.svh
// register map, field positions, reset values and timing of the host serial port
// assumes a 50 MHz system clock and a 32-bit plain register port
`ifndef HSP_MAP_SVH
`define HSP_MAP_SVH

`define HSP_CLK_HZ 50000000
`define HSP_BAUD_DEF 115200
`define HSP_DIV_DEF (16'(`HSP_CLK_HZ / `HSP_BAUD_DEF))

`define HSP_AW 4
`define HSP_ADDR_CTRL 4'h0
`define HSP_ADDR_STAT 4'h4
`define HSP_ADDR_DATA 4'h8

`define HSP_CTRL_DIV_HI 15
`define HSP_CTRL_FLOW 16
`define HSP_CTRL_PAR_LO 17
`define HSP_CTRL_PAR_HI 18
`define HSP_CTRL_STOP2 19
`define HSP_CTRL_FRAMED 20

`define HSP_PAR_NONE 2'h0
`define HSP_PAR_ODD 2'h1
`define HSP_PAR_EVEN 2'h2

`define HSP_ST_RXAVL 0
`define HSP_ST_TXFULL 1
`define HSP_ST_TXBUSY 2
`define HSP_ST_PERR 3
`define HSP_ST_FERR 4
`define HSP_ST_OVR 5
`define HSP_ST_DELIM 6

`define HSP_FIFO_W 8
`define HSP_FIFO_D 8
`define HSP_RTS_STOP_LVL 4'h6
`define HSP_FRAME_DELIM 8'hC0

`endif

// >>> logic/hsp_pkg.sv
// types shared by the host serial port
// assumes hsp_map.svh for all numeric constants
package hsp_pkg;
    typedef enum logic [2:0] {
        HSP_TX_IDLE, HSP_TX_START, HSP_TX_DATA, HSP_TX_PAR, HSP_TX_STOP
    } hsp_tx_e;
    typedef enum logic [2:0] {
        HSP_RX_IDLE, HSP_RX_START, HSP_RX_DATA, HSP_RX_PAR, HSP_RX_STOP
    } hsp_rx_e;
    typedef logic [7:0] hsp_byte_t;
endpackage

// >>> logic/hsp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/10ps
module hsp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] count
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem_ff [D];
    logic [PW-1:0] wptr_ff;
    logic [PW-1:0] rptr_ff;
    logic [PW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != (PW+1)'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rptr_ff];
    assign count = cnt_ff;
    assign push = in_valid && in_ready;
    assign pop = out_ready && out_valid;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wptr_ff <= PW'(wptr_ff + 1'b1);
            end
            if (pop) begin
                rptr_ff <= PW'(rptr_ff + 1'b1);
            end
            cnt_ff <= (PW+1)'(cnt_ff + push - pop);
        end
    end
endmodule

// >>> logic/hsp_uart.sv
// serial port through which a host exchanges bytes with the module
// assumes 50 MHz clk, plain register port, host-side pins asynchronous
//
// Contract
// R1 - data leaves on ser_out, arrives on ser_in, one line each way
// R2 - rts_n and cts_n are both asserted when low
// R3 - module drives rts_n; host drives cts_n, an input here
// R4 - bit rate set by divisor, 1200 bps to about 921 kbps
// R5 - flow control selectable: rts/cts handshake or none
// R6 - every frame carries exactly eight data bits
// R7 - parity none, odd or even; sent by transmitter, checked by receiver
// R8 - one or two stop bits end each frame
// R9 - framed link protocol assist can be switched on or off
// R10 - reset format: 115.2 kbps, no flow control, 8N1
// R11 - low start bit, data lsb first, parity, high stops; idle high
// R12 - with flow control: drop rts when full, hold tx while cts high; rts is dropped once the rx fifo holds 6 of its 8 entries
`timescale 1ns/10ps
`include "hsp_map.svh"
module hsp_uart (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`HSP_AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic ser_out,
    input wire logic ser_in,
    output logic rts_n,
    input wire logic cts_n
);
    import hsp_pkg::*;

    // configuration
    logic [15:0] div_ff;
    logic [1:0] par_ff;
    logic flow_ff, stop2_ff, framed_ff;
    // pin synchronisers
    logic rx_m_ff, rx_s_ff, cts_m_ff, cts_s_ff;
    // sticky status and registered outputs
    logic perr_ff, ferr_ff, ovr_ff, delim_ff;
    logic [31:0] rdata_ff;
    logic ser_out_ff, rts_n_ff;
    // transmit path
    hsp_tx_e tx_st_ff;
    logic [15:0] tx_cnt_ff;
    logic [2:0] tx_bit_ff;
    hsp_byte_t tx_sh_ff, tx_out_data;
    logic tx_par_ff, tx_stop_left_ff, tx_tick, tx_pop, tx_exp_par;
    logic tx_in_ready, tx_out_valid;
    // receive path
    hsp_rx_e rx_st_ff;
    logic [15:0] rx_cnt_ff;
    logic [2:0] rx_bit_ff;
    hsp_byte_t rx_sh_ff, rx_out_data;
    logic rx_par_bad_ff, rx_tick, rx_done, rx_push, rx_exp_par, rx_bad;
    logic rx_in_ready, rx_out_valid, rx_pop;
    logic [3:0] rx_count;
    logic wr_ctrl, wr_stat, wr_data, rd_data;

    assign wr_ctrl = wr && (addr == `HSP_ADDR_CTRL);
    assign wr_stat = wr && (addr == `HSP_ADDR_STAT);
    assign wr_data = wr && (addr == `HSP_ADDR_DATA);
    assign rd_data = rd && (addr == `HSP_ADDR_DATA);

    assign rdata = rdata_ff;
    assign ser_out = ser_out_ff;
    assign rts_n = rts_n_ff;

    // R10 reset format
    // R4 bit rate divisor
    // R5 flow select
    // R9 assist enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= `HSP_DIV_DEF;
            flow_ff <= 1'b0;
            par_ff <= `HSP_PAR_NONE;
            stop2_ff <= 1'b0;
            framed_ff <= 1'b0;
        end else if (wr_ctrl) begin
            div_ff <= wdata[`HSP_CTRL_DIV_HI:0];
            flow_ff <= wdata[`HSP_CTRL_FLOW];
            par_ff <= wdata[`HSP_CTRL_PAR_HI:`HSP_CTRL_PAR_LO];
            stop2_ff <= wdata[`HSP_CTRL_STOP2];
            framed_ff <= wdata[`HSP_CTRL_FRAMED];
        end
    end

    // R1 two dedicated lines
    // R3 cts is an input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_m_ff <= 1'b1;
            rx_s_ff <= 1'b1;
            cts_m_ff <= 1'b1;
            cts_s_ff <= 1'b1;
        end else begin
            rx_m_ff <= ser_in;
            rx_s_ff <= rx_m_ff;
            cts_m_ff <= cts_n;
            cts_s_ff <= cts_m_ff;
        end
    end

    hsp_fifo #(
        .W(`HSP_FIFO_W),
        .D(`HSP_FIFO_D)
    ) u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wr_data),
        .in_ready(tx_in_ready),
        .in_data(wdata[7:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_pop),
        .out_data(tx_out_data),
        .count()
    );

    hsp_fifo #(
        .W(`HSP_FIFO_W),
        .D(`HSP_FIFO_D)
    ) u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data(rx_sh_ff),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_out_data),
        .count(rx_count)
    );

    // R12 hold tx while cts high
    // R2 cts low means clear
    assign tx_pop = (tx_st_ff == HSP_TX_IDLE) && tx_out_valid &&
                    (!flow_ff || !cts_s_ff);
    assign tx_tick = (tx_cnt_ff == 16'h0000);
    // R7 parity sense
    assign tx_exp_par = (^tx_out_data) ^ (par_ff == `HSP_PAR_ODD);

    // R11 frame order
    // R6 eight data bits
    // R8 stop count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_ff <= HSP_TX_IDLE;
            tx_cnt_ff <= 16'h0000;
            tx_bit_ff <= 3'h0;
            tx_sh_ff <= 8'h00;
            tx_par_ff <= 1'b0;
            tx_stop_left_ff <= 1'b0;
            ser_out_ff <= 1'b1;
        end else begin
            tx_cnt_ff <= tx_tick ? div_ff - 16'h0001
                                 : tx_cnt_ff - 16'h0001;
            unique case (tx_st_ff)
                HSP_TX_IDLE: begin
                    ser_out_ff <= 1'b1;
                    if (tx_pop) begin
                        tx_sh_ff <= tx_out_data;
                        tx_par_ff <= tx_exp_par;
                        tx_stop_left_ff <= stop2_ff;
                        tx_cnt_ff <= div_ff - 16'h0001;
                        ser_out_ff <= 1'b0;
                        tx_st_ff <= HSP_TX_START;
                    end
                end
                HSP_TX_START: begin
                    if (tx_tick) begin
                        ser_out_ff <= tx_sh_ff[0];
                        tx_bit_ff <= 3'h0;
                        tx_st_ff <= HSP_TX_DATA;
                    end
                end
                HSP_TX_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit_ff == 3'h7) begin
                            if (par_ff != `HSP_PAR_NONE) begin
                                ser_out_ff <= tx_par_ff;
                                tx_st_ff <= HSP_TX_PAR;
                            end else begin
                                ser_out_ff <= 1'b1;
                                tx_st_ff <= HSP_TX_STOP;
                            end
                        end else begin
                            ser_out_ff <= tx_sh_ff[1];
                            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                            tx_bit_ff <= tx_bit_ff + 3'h1;
                        end
                    end
                end
                HSP_TX_PAR: begin
                    if (tx_tick) begin
                        ser_out_ff <= 1'b1;
                        tx_st_ff <= HSP_TX_STOP;
                    end
                end
                HSP_TX_STOP: begin
                    if (tx_tick) begin
                        if (tx_stop_left_ff) begin
                            tx_stop_left_ff <= 1'b0;
                        end else begin
                            tx_st_ff <= HSP_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign rx_tick = (rx_cnt_ff == 16'h0000);
    assign rx_done = (rx_st_ff == HSP_RX_STOP) && rx_tick;
    assign rx_exp_par = (^rx_sh_ff) ^ (par_ff == `HSP_PAR_ODD);
    assign rx_bad = rx_par_bad_ff || !rx_s_ff;
    // R9 assist drops damaged characters
    assign rx_push = rx_done && !(framed_ff && rx_bad);

    // R11 sample at bit centre
    // R7 parity check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_ff <= HSP_RX_IDLE;
            rx_cnt_ff <= 16'h0000;
            rx_bit_ff <= 3'h0;
            rx_sh_ff <= 8'h00;
            rx_par_bad_ff <= 1'b0;
        end else begin
            rx_cnt_ff <= rx_tick ? div_ff - 16'h0001
                                 : rx_cnt_ff - 16'h0001;
            unique case (rx_st_ff)
                HSP_RX_IDLE: begin
                    if (!rx_s_ff) begin
                        rx_cnt_ff <= {1'b0, div_ff[15:1]};
                        rx_par_bad_ff <= 1'b0;
                        rx_st_ff <= HSP_RX_START;
                    end
                end
                HSP_RX_START: begin
                    if (rx_tick) begin
                        rx_bit_ff <= 3'h0;
                        rx_st_ff <= rx_s_ff ? HSP_RX_IDLE : HSP_RX_DATA;
                    end
                end
                HSP_RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh_ff <= {rx_s_ff, rx_sh_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == 3'h7) begin
                            rx_st_ff <= (par_ff != `HSP_PAR_NONE) ?
                                        HSP_RX_PAR : HSP_RX_STOP;
                        end
                    end
                end
                HSP_RX_PAR: begin
                    if (rx_tick) begin
                        rx_par_bad_ff <= rx_s_ff ^ rx_exp_par;
                        rx_st_ff <= HSP_RX_STOP;
                    end
                end
                HSP_RX_STOP: begin
                    if (rx_tick) begin
                        rx_st_ff <= HSP_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // sticky errors, set wins over write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perr_ff <= 1'b0;
            ferr_ff <= 1'b0;
            ovr_ff <= 1'b0;
            delim_ff <= 1'b0;
        end else begin
            perr_ff <= (rx_done && rx_par_bad_ff) ||
                       (perr_ff && !(wr_stat && wdata[`HSP_ST_PERR]));
            ferr_ff <= (rx_done && !rx_s_ff) ||
                       (ferr_ff && !(wr_stat && wdata[`HSP_ST_FERR]));
            ovr_ff <= (rx_push && !rx_in_ready) ||
                      (ovr_ff && !(wr_stat && wdata[`HSP_ST_OVR]));
            // R9 frame delimiter seen
            delim_ff <= (rx_push && framed_ff &&
                         rx_sh_ff == `HSP_FRAME_DELIM) ||
                        (delim_ff && !(wr_stat && wdata[`HSP_ST_DELIM]));
        end
    end

    // R12 drop rts near full
    // R2 rts low means ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rts_n_ff <= 1'b1;
        end else begin
            rts_n_ff <= flow_ff && (rx_count >= `HSP_RTS_STOP_LVL);
        end
    end

    assign rx_pop = rd_data && rx_out_valid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= 32'h0000_0000;
            if (rd) begin
                unique case (addr)
                    `HSP_ADDR_CTRL: begin
                        rdata_ff[`HSP_CTRL_DIV_HI:0] <= div_ff;
                        rdata_ff[`HSP_CTRL_FLOW] <= flow_ff;
                        rdata_ff[`HSP_CTRL_PAR_HI:`HSP_CTRL_PAR_LO] <= par_ff;
                        rdata_ff[`HSP_CTRL_STOP2] <= stop2_ff;
                        rdata_ff[`HSP_CTRL_FRAMED] <= framed_ff;
                    end
                    `HSP_ADDR_STAT: begin
                        rdata_ff[`HSP_ST_RXAVL] <= rx_out_valid;
                        rdata_ff[`HSP_ST_TXFULL] <= !tx_in_ready;
                        rdata_ff[`HSP_ST_TXBUSY] <=
                            (tx_st_ff != HSP_TX_IDLE) || tx_out_valid;
                        rdata_ff[`HSP_ST_PERR] <= perr_ff;
                        rdata_ff[`HSP_ST_FERR] <= ferr_ff;
                        rdata_ff[`HSP_ST_OVR] <= ovr_ff;
                        rdata_ff[`HSP_ST_DELIM] <= delim_ff;
                    end
                    `HSP_ADDR_DATA: begin
                        if (rx_out_valid) begin
                            rdata_ff[7:0] <= rx_out_data;
                        end
                    end
                    default: begin
                        rdata_ff <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule

// >>> tb/hsp_uart_assertions.sv
// checker watching the ports of the host serial port
// assumes format changes only while the line is idle
`timescale 1ns/10ps
`include "hsp_map.svh"
module hsp_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`HSP_AW-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic ser_out,
    input wire logic ser_in,
    input wire logic rts_n,
    input wire logic cts_n
);
    logic [20:0] ctl_ff;
    logic seen_ff;
    logic [31:0] lo_ff, hi_ff, cts_ff, div;
    logic flow;
    assign div = {16'h0, ctl_ff[15:0]};
    assign flow = ctl_ff[`HSP_CTRL_FLOW];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= {5'h0, `HSP_DIV_DEF};
        end else if (wr && addr == `HSP_ADDR_CTRL) begin
            ctl_ff <= wdata[20:0];
        end
    end
    // run lengths of the line and of a held-off cts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_ff <= 1'b0;
            lo_ff <= 32'h0;
            hi_ff <= 32'h0;
            cts_ff <= 32'h0;
        end else begin
            seen_ff <= 1'b1;
            lo_ff <= ser_out ? 32'h0 : lo_ff + 32'h1;
            hi_ff <= ser_out ? hi_ff + 32'h1 : 32'h0;
            cts_ff <= (flow && cts_n) ? cts_ff + 32'h1 : 32'h0;
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_tx_req;
        wr && addr == `HSP_ADDR_DATA && !flow && hi_ff > 11 * div;
    endsequence
    sequence s_start;
        ##[1:4] !ser_out;
    endsequence
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside answer");
    AST_RD_HOLE: assert property (rd && addr == 4'hC |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_CTRL_RD: assert property (rd && addr == `HSP_ADDR_CTRL
        |=> rdata[20:0] == $past(ctl_ff)) else $error("ctrl readback");
    AST_RTS_OFF: assert property (seen_ff && !flow && $stable(flow)
        |-> !rts_n) else $error("rts high without flow control");
    AST_LOW_SPAN: assert property ($rose(ser_out)
        |-> lo_ff % div == 32'h0) else $error("low span not whole bits");
    AST_LOW_MAX: assert property ($rose(ser_out) |-> lo_ff <= div *
        (ctl_ff[`HSP_CTRL_PAR_HI:`HSP_CTRL_PAR_LO] != 2'h0 ? 10 : 9))
        else $error("low span longer than a frame allows");
    AST_TX_GO: assert property (s_tx_req |-> s_start)
        else $error("start bit late after data write");
    AST_CTS_HOLD: assert property (cts_ff > 12 * div + 8 |-> ser_out)
        else $error("frame sent while cts deasserted");
endmodule
bind hsp_uart hsp_chk u_hsp_chk (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .ser_out(ser_out), .ser_in(ser_in),
    .rts_n(rts_n), .cts_n(cts_n)
);

// >>> tb/hsp_host.sv
// host serial port model: sends frames and collects received ones
// assumes the bench sets div, par and stop2 to match the port
`timescale 1ns/10ps
`include "hsp_map.svh"
module hsp_host (
    input wire logic clk,
    input wire logic ser_out,
    output logic ser_in,
    output logic cts_n
);
    import hsp_pkg::*;
    int div = 434;
    logic [1:0] par = 2'h0;
    logic stop2 = 1'b0;
    logic stall = 1'b0;
    logic bad = 1'b0;
    hsp_byte_t got[$];
    assign cts_n = stall;
    initial ser_in = 1'b1;
    function automatic logic pbit(hsp_byte_t b);
        return (par == `HSP_PAR_ODD) ? ~^b : ^b;
    endfunction
    task automatic send(hsp_byte_t b, logic flip);
        logic q[$];
        q.push_back(1'b0);
        for (int i = 0; i < 8; i++) q.push_back(b[i]);
        if (par != `HSP_PAR_NONE) q.push_back(pbit(b) ^ flip);
        q.push_back(1'b1);
        if (stop2) q.push_back(1'b1);
        foreach (q[i]) begin
            @(posedge clk);
            ser_in <= q[i];
            repeat (div - 1) @(posedge clk);
        end
    endtask
    initial begin
        hsp_byte_t b;
        forever begin
            @(negedge ser_out);
            repeat (div / 2) @(posedge clk);
            if (ser_out !== 1'b0) bad = 1'b1;
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge clk);
                b[i] = ser_out;
            end
            if (par != `HSP_PAR_NONE) begin
                repeat (div) @(posedge clk);
                if (ser_out !== pbit(b)) bad = 1'b1;
            end
            repeat (stop2 ? 2 : 1) begin
                repeat (div) @(posedge clk);
                if (ser_out !== 1'b1) bad = 1'b1;
            end
            got.push_back(b);
        end
    end
endmodule

// >>> tb/test_hsp_uart.sv
// self-checking bench for the host serial port
// assumes the host model on the serial pins and a 50 MHz clock
`timescale 1ns/10ps
`include "hsp_map.svh"
module test_hsp_uart;
    import hsp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`HSP_AW-1:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic ser_out, ser_in, rts_n, cts_n;
    int errors = 0;
    int checked = 0;
    hsp_uart u_hsp_uart (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ser_out(ser_out),
        .ser_in(ser_in), .rts_n(rts_n), .cts_n(cts_n));
    hsp_host u_hsp_host (.clk(clk), .ser_out(ser_out), .ser_in(ser_in),
        .cts_n(cts_n));
    initial forever #10 clk = ~clk;
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic reg_wr(logic [`HSP_AW-1:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(logic [`HSP_AW-1:0] a, logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask
    task automatic cfg(int dv, logic [1:0] p, logic s2, logic fl, logic fa);
        reg_wr(`HSP_ADDR_CTRL, {11'h0, fa, s2, p, fl, 16'(dv)});
        u_hsp_host.div = dv;
        u_hsp_host.par = p;
        u_hsp_host.stop2 = s2;
    endtask
    task automatic take(hsp_byte_t exp);
        for (int k = 0; k < 9000 && u_hsp_host.got.size() == 0; k++)
            @(posedge clk);
        check(u_hsp_host.got.size() > 0 ? u_hsp_host.got.pop_front()
            : 32'h1FF, {24'h0, exp});
    endtask
    task automatic t_reset();
        rd_chk(`HSP_ADDR_CTRL, {16'h0, `HSP_DIV_DEF});
        rd_chk(`HSP_ADDR_STAT, 32'h0);
        rd_chk(4'hC, 32'h0);
        check(rts_n, 1'b0);
        u_hsp_host.send(8'h5A, 1'b0);
        rd_chk(`HSP_ADDR_DATA, 32'h5A);
        reg_wr(`HSP_ADDR_DATA, 32'hC3);
        take(8'hC3);
    endtask
    task automatic t_formats();
        hsp_byte_t b;
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 2; s++) begin
                b = 8'(8'h96 + p * 16 + s);
                cfg(54, 2'(p), 1'(s), 1'b0, 1'b0);
                u_hsp_host.send(b, 1'b0);
                rd_chk(`HSP_ADDR_DATA, {24'h0, b});
                rd_chk(`HSP_ADDR_STAT, 32'h0);
                reg_wr(`HSP_ADDR_DATA, {24'h0, b});
                reg_wr(`HSP_ADDR_DATA, {24'h0, ~b});
                take(b);
                take(~b);
                // let the last stop bits leave before reformatting
                repeat (120) @(posedge clk);
            end
        end
        check(u_hsp_host.bad, 1'b0);
    endtask
    task automatic t_errors();
        cfg(54, `HSP_PAR_EVEN, 1'b0, 1'b0, 1'b0);
        u_hsp_host.send(8'h3E, 1'b1);
        rd_chk(`HSP_ADDR_STAT, 32'h9);
        rd_chk(`HSP_ADDR_DATA, 32'h3E);
        reg_wr(`HSP_ADDR_STAT, 32'h8);
        cfg(54, `HSP_PAR_EVEN, 1'b0, 1'b0, 1'b1);
        u_hsp_host.send(8'h3E, 1'b1);
        rd_chk(`HSP_ADDR_STAT, 32'h8);
        reg_wr(`HSP_ADDR_STAT, 32'h8);
        u_hsp_host.send(`HSP_FRAME_DELIM, 1'b0);
        rd_chk(`HSP_ADDR_STAT, 32'h41);
        rd_chk(`HSP_ADDR_DATA, 32'hC0);
        reg_wr(`HSP_ADDR_STAT, 32'h40);
        rd_chk(`HSP_ADDR_STAT, 32'h0);
    endtask
    task automatic t_flow();
        cfg(54, `HSP_PAR_NONE, 1'b0, 1'b1, 1'b0);
        u_hsp_host.stall <= 1'b1;
        for (int i = 0; i < 9; i++) reg_wr(`HSP_ADDR_DATA, 32'(i + 16));
        rd_chk(`HSP_ADDR_STAT, 32'h6);
        repeat (1200) @(posedge clk);
        check(u_hsp_host.got.size(), 32'h0);
        u_hsp_host.stall <= 1'b0;
        for (int i = 0; i < 8; i++) take(8'(i + 16));
        for (int i = 0; i < 9; i++) begin
            if (i == 5) check(rts_n, 1'b0);
            if (i == 6) check(rts_n, 1'b1);
            u_hsp_host.send(8'(i + 32), 1'b0);
        end
        rd_chk(`HSP_ADDR_STAT, 32'h21);
        for (int i = 0; i < 8; i++) rd_chk(`HSP_ADDR_DATA, 32'(i + 32));
        check(rts_n, 1'b0);
        check(u_hsp_host.got.size(), 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_formats();
        t_errors();
        t_flow();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule
